// ==== hw/cbb_top.sv ====
module cbb_top
(
  // Clock and reset
  input  wire logic                CLK_SYS_I,
  input  wire logic                RST_I,
  // Instruction fetch
  input  wire logic                IF_REQ_I,
  input  wire logic [31:0]         IF_VADDR_I,
  output logic                     IF_VALID_O,
  output logic [31:0]              IF_DATA_O,
  // Data load
  input  wire logic                LD_REQ_I,
  input  wire logic [31:0]         LD_VADDR_I,
  output logic                     LD_VALID_O,
  output logic [31:0]              LD_DATA_O,
  // Data store
  input  wire cbb_pkg::cbb_store_t ST_I,
  output logic                     ST_READY_O,
  // Multiplexed memory bus
  input  wire logic [31:0]         AD_I,
  output logic [31:0]              AD_O,
  output logic                     AD_OE_O,
  output logic                     ALE_O,
  output logic [1:0]               ADDR_LO_O,
  output logic                     RD_N_O,
  output logic                     WR_N_O,
  input  wire logic                ACK_I,
  input  wire logic                BURST_I,
  // External master arbitration
  input  wire logic                DMA_REQ_I,
  output logic                     DMA_GRANT_O
);
  import cbb_pkg::*;

  // ----------------------------------------
  // Address mapping
  // ----------------------------------------
  // Reserved regions fall through the same arms as their segment
  function automatic logic [31:0] map_pa(input logic [31:0] va);
    if (va[31:30] == SEG_KSEG01)
      map_pa = {3'b000, va[28:0]};
    else if (!va[31])
      map_pa = va + USEG_OFFSET;
    else
      map_pa = va;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
  endfunction

  cbb_state_t                  state;
  logic [IC_TAG_W-1:0]         ic_tag   [IC_LINES];
  logic [IC_LINES-1:0]         ic_val;
  logic [31:0]                 ic_data  [IC_LINES][4];
  logic [DC_TAG_W-1:0]         dc_tag   [DC_LINES];
  logic [DC_LINES-1:0]         dc_val;
  logic [31:0]                 dc_data  [DC_LINES];
  cbb_wb_entry_t               wb       [WB_DEPTH];
  logic [1:0]                  wb_rd;
  logic [1:0]                  wb_wr;
  logic [2:0]                  wb_cnt;
  logic [31:0]                 rb       [RB_DEPTH];
  logic [31:0]                 cur_pa;
  logic [31:0]                 cur_data;
  logic [3:0]                  cur_be;
  logic                        cur_wr;
  logic                        cur_quad;
  logic                        cur_unc;
  logic [1:0]                  cnt;
  logic                        burst_on;

  // ----------------------------------------
  // Lookup
  // ----------------------------------------
  wire [31:0]         if_pa   = map_pa(IF_VADDR_I);
  wire [31:0]         ld_pa   = map_pa(LD_VADDR_I);
  wire [31:0]         st_pa   = map_pa(ST_I.vaddr);
  wire [IC_IDX_W-1:0] if_idx  = if_pa[IC_IDX_W+3:4];
  wire [DC_IDX_W-1:0] ld_idx  = ld_pa[DC_IDX_W+1:2];
  wire [DC_IDX_W-1:0] st_idx  = st_pa[DC_IDX_W+1:2];
  wire                if_unc  = IF_VADDR_I[31:29] == SEG_KSEG1;
  wire                ld_unc  = LD_VADDR_I[31:29] == SEG_KSEG1;
  wire                if_hit  = !if_unc && ic_val[if_idx]
                                && ic_tag[if_idx] == if_pa[31:IC_IDX_W+4];
  wire                ld_hit  = !ld_unc && dc_val[ld_idx]
                                && dc_tag[ld_idx] == ld_pa[31:DC_IDX_W+2];
  wire                st_hit  = dc_val[st_idx] && dc_tag[st_idx] == st_pa[31:DC_IDX_W+2];
  wire                if_miss = IF_REQ_I && !IF_VALID_O && !if_hit;
  wire                ld_miss = LD_REQ_I && !LD_VALID_O && !ld_hit;
  wire                wb_full = wb_cnt == 3'(WB_DEPTH);
  wire                wb_push = ST_I.valid && !wb_full;
  wire                wb_pop  = state == ST_WRITE && ACK_I;
  wire                rd_take = state == ST_READ && (ACK_I || burst_on);
  wire                rd_last = rd_take && (!cur_quad || cnt == WORD_LAST);
  wire [IC_IDX_W-1:0] fi_idx  = cur_pa[IC_IDX_W+3:4];
  wire [DC_IDX_W-1:0] fd_idx  = cur_pa[DC_IDX_W+1:2];

  assign ST_READY_O  = !wb_full;
  assign ALE_O       = state == ST_ADDR;
  assign AD_OE_O     = state inside {ST_ADDR, ST_WRITE};
  assign AD_O        = ALE_O ? {cur_pa[31:4], ~cur_be} : cur_data;
  assign ADDR_LO_O   = cur_quad ? cnt : cur_pa[3:2];
  assign RD_N_O      = state != ST_READ;
  assign WR_N_O      = state != ST_WRITE;
  assign DMA_GRANT_O = state == ST_GRANT;

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  // Reads wait for an empty write buffer so memory never serves stale data
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state    <= ST_IDLE;
      cur_pa   <= '0;
      cur_data <= '0;
      cur_be   <= '0;
      cur_wr   <= 1'b0;
      cur_quad <= 1'b0;
      cur_unc  <= 1'b0;
      cnt      <= WORD_FIRST;
      burst_on <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          cnt      <= WORD_FIRST;
          burst_on <= 1'b0;
          if (DMA_REQ_I)
            state <= ST_GRANT;
          else if (wb_cnt != 3'd0)
          begin
            cur_pa   <= wb[wb_rd].pa;
            cur_data <= wb[wb_rd].data;
            cur_be   <= wb[wb_rd].be;
            cur_wr   <= 1'b1;
            cur_quad <= 1'b0;
            state    <= ST_ADDR;
          end
          else if (if_miss || ld_miss)
          begin
            cur_pa   <= if_miss ? if_pa : ld_pa;
            cur_be   <= ~BE_N_ALL;
            cur_wr   <= 1'b0;
            cur_quad <= if_miss;
            cur_unc  <= if_miss ? if_unc : ld_unc;
            state    <= ST_ADDR;
          end
        end
        ST_ADDR:  state <= cur_wr ? ST_WRITE : ST_READ;
        ST_WRITE: if (ACK_I) state <= ST_IDLE;
        ST_READ:
        begin
          if (rd_take)
            cnt <= cnt + 2'd1;
          if (ACK_I && cur_quad && BURST_I)
            burst_on <= 1'b1;
          if (rd_last)
            state <= ST_FILL;
        end
        ST_FILL:  state <= ST_IDLE;
        ST_GRANT: if (!DMA_REQ_I) state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  generate
    for (genvar w = 0; w < RB_DEPTH; w++)
    begin : g_rb
      always_ff @(posedge CLK_SYS_I or posedge RST_I)
      begin
        if (RST_I)
          rb[w] <= '0;
        else if (rd_take && cnt == 2'(w))
          rb[w] <= AD_I;
      end
    end
  endgenerate

  // ----------------------------------------
  // Write buffer
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      wb_rd  <= '0;
      wb_wr  <= '0;
      wb_cnt <= '0;
    end
    else
    begin
      if (wb_push)
      begin
        wb[wb_wr] <= '{pa: st_pa, be: ST_I.be, data: ST_I.data};
        wb_wr     <= wb_wr + 2'd1;
      end
      if (wb_pop)
        wb_rd <= wb_rd + 2'd1;
      wb_cnt <= wb_cnt + 3'(wb_push) - 3'(wb_pop);
    end
  end

  // ----------------------------------------
  // Cache arrays and core answers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ic_val     <= '0;
      dc_val     <= '0;
      IF_VALID_O <= 1'b0;
      IF_DATA_O  <= '0;
      LD_VALID_O <= 1'b0;
      LD_DATA_O  <= '0;
    end
    else
    begin
      IF_VALID_O <= IF_REQ_I && !IF_VALID_O && if_hit;
      IF_DATA_O  <= ic_data[if_idx][if_pa[3:2]];
      LD_VALID_O <= LD_REQ_I && !LD_VALID_O && ld_hit;
      LD_DATA_O  <= dc_data[ld_idx];
      if (wb_push && st_hit)
        dc_data[st_idx] <= merge(dc_data[st_idx], ST_I.data, ST_I.be);
      if (state == ST_FILL && cur_quad)
      begin
        for (int w = 0; w < RB_DEPTH; w++)
          ic_data[fi_idx][w] <= rb[w];
        ic_tag[fi_idx] <= cur_pa[31:IC_IDX_W+4];
        ic_val[fi_idx] <= !cur_unc;
        if (cur_unc)
        begin
          IF_VALID_O <= 1'b1;
          IF_DATA_O  <= rb[cur_pa[3:2]];
        end
      end
      if (state == ST_FILL && !cur_quad)
      begin
        dc_data[fd_idx] <= rb[0];
        dc_tag[fd_idx]  <= cur_pa[31:DC_IDX_W+2];
        dc_val[fd_idx]  <= !cur_unc;
        if (cur_unc)
        begin
          LD_VALID_O <= 1'b1;
          LD_DATA_O  <= rb[0];
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  sequence s_addr_phase; ALE_O && AD_OE_O; endsequence
  sequence s_read_phase; !RD_N_O && !ALE_O; endsequence

  property p_full_stall; wb_full |=> wb_cnt <= $past(wb_cnt); endproperty
  a_full_stall: assert property (p_full_stall) else $error("store taken when full");
  property p_push_count; wb_push && !wb_pop |=> wb_cnt == $past(wb_cnt) + 3'd1; endproperty
  a_push_count: assert property (p_push_count) else $error("buffer count wrong");
  property p_fifo; ALE_O && cur_wr |-> cur_pa == wb[wb_rd].pa; endproperty
  a_fifo: assert property (p_fifo) else $error("write out of order");
  property p_ale; s_addr_phase |=> !ALE_O; endproperty
  a_ale: assert property (p_ale) else $error("latch strobe too long");
  property p_strobes; ALE_O |-> AD_O[3:0] == (cur_wr ? ~wb[wb_rd].be : BE_N_ALL); endproperty
  a_strobes: assert property (p_strobes) else $error("byte lanes wrong");
  property p_grant; DMA_GRANT_O |-> !AD_OE_O && RD_N_O && WR_N_O; endproperty
  a_grant: assert property (p_grant) else $error("bus driven under grant");
  property p_read; ALE_O && !cur_wr |=> s_read_phase; endproperty
  a_read: assert property (p_read) else $error("read phase missing");
  property p_quad_start; ALE_O && cur_quad |-> ADDR_LO_O == WORD_FIRST; endproperty
  a_quad_start: assert property (p_quad_start) else $error("burst not from 00");
  property p_burst; burst_on && !RD_N_O && !rd_last |=> ADDR_LO_O == $past(ADDR_LO_O) + 2'd1;
  endproperty
  a_burst: assert property (p_burst) else $error("burst word not per clock");
  property p_fill; state == ST_FILL && cur_quad |-> $past(cnt) == WORD_LAST; endproperty
  a_fill: assert property (p_fill) else $error("fill before four words");
endmodule

// ==== hw/cbb_pkg.sv ====
// Function
// - Instruction cache of 4kB, 16-byte lines of four words.
// - Instruction cache direct mapped, physically indexed and tagged, no task-switch flush.
// - Data cache of 2kB with one-word lines.
// - Data cache direct mapped on physical address over the full 4GB space.
// - Data cache is write-through; every store also goes to memory.
// - Four-entry write buffer takes stores at core rate, drains at memory rate.
// - Buffered stores leave as bus writes in FIFO order, paced by handshake.
// - Address and data share 32 pins; a latch strobe marks the address.
// - Arbiter lets an external master request and take the bus.
// - Single-word and four-word reads; single reads end on memory handshake.
// - Four-word reads use per-word handshake or one word per clock burst.
// - Four-entry read buffer collects a quad read, then burst-fills the cache.
// - Reserved regions translate like their segment, with no trap.
// - Low word address gives the word, counting up from 00 in bursts.
// - Address phase low four bits carry active-low byte-lane strobes.
package cbb_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int IC_BYTES   = 4096;
  localparam int IC_LINE_B  = 16;
  localparam int IC_LINES   = IC_BYTES / IC_LINE_B;
  localparam int IC_IDX_W   = $clog2(IC_LINES);
  localparam int IC_TAG_W   = 32 - IC_IDX_W - 4;
  localparam int DC_BYTES   = 2048;
  localparam int DC_LINES   = DC_BYTES / 4;
  localparam int DC_IDX_W   = $clog2(DC_LINES);
  localparam int DC_TAG_W   = 32 - DC_IDX_W - 2;
  localparam int WB_DEPTH   = 4;
  localparam int RB_DEPTH   = 4;
  // ----------------------------------------
  // Fixed segment mapping, byte strobes and word order
  // ----------------------------------------
  localparam logic [1:0]  SEG_KSEG01   = 2'b10;
  localparam logic [2:0]  SEG_KSEG1    = 3'b101;
  localparam logic [31:0] USEG_OFFSET  = 32'h4000_0000;
  localparam logic [3:0]  BE_N_ALL     = 4'h0;
  localparam logic [1:0]  WORD_FIRST   = 2'h0;
  localparam logic [1:0]  WORD_LAST    = 2'h3;

  typedef struct packed {
    logic        valid;
    logic [31:0] vaddr;
    logic [3:0]  be;
    logic [31:0] data;
  } cbb_store_t;

  typedef struct packed {
    logic [31:0] pa;
    logic [3:0]  be;
    logic [31:0] data;
  } cbb_wb_entry_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_ADDR  = 6'b00_0010,
    ST_WRITE = 6'b00_0100,
    ST_READ  = 6'b00_1000,
    ST_FILL  = 6'b01_0000,
    ST_GRANT = 6'b10_0000
  } cbb_state_t;
endpackage

// ==== dv/cbb_mem_model.sv ====
module cbb_mem_model
(
  // Device side
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] ad_i,
  input  wire logic        ale_i,
  input  wire logic [1:0]  lo_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  // Pacing
  input  wire logic [3:0]  dly_i,
  input  wire logic        burst_i,
  // Answers
  output logic [31:0]      ad_o,
  output logic             ack_o,
  output logic             burst_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [logic [31:0]];
  logic [63:0] rd_q [$];
  logic [63:0] wr_q [$];
  logic [31:0] adr;
  logic [31:0] last;
  logic [3:0]  cnt;
  logic        strm;
  int          cyc = 0;
  wire  [31:0] pa   = {adr[31:4], lo_i, 2'b00};
  wire  [31:0] keep = {{8{adr[3]}}, {8{adr[2]}}, {8{adr[1]}}, {8{adr[0]}}};
  wire         busy = !rd_n_i || !wr_n_i;

  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'h5A5A_0000;
  endfunction

  // Inverse of the last word, so a stale value never passes as data
  assign ack_o   = busy && (strm || cnt == dly_i);
  assign burst_o = burst_i && !rd_n_i;
  assign ad_o    = (ack_o && !rd_n_i) ? peek(pa) : ~last;

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt  <= 4'h0;
      strm <= 1'b0;
      last <= 32'h0000_0000;
    end
    else
    begin
      cyc  <= cyc + 1;
      cnt  <= (busy && !ack_o) ? cnt + 4'h1 : 4'h0;
      strm <= !rd_n_i && (strm || (ack_o && burst_i));
      adr  <= ale_i ? ad_i : adr;
      last <= (ack_o && !rd_n_i) ? ad_o : last;
      if (ack_o && !rd_n_i)
        rd_q.push_back({32'(cyc), pa});
      if (ack_o && !wr_n_i)
        mem[pa] = (peek(pa) & keep) | (ad_i & ~keep);
      if (ack_o && !wr_n_i)
        wr_q.push_back({adr, ad_i});
    end
  end
endmodule

// ==== dv/test_cbb_top.sv ====
module test_cbb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cbb_pkg::*;
  logic        clk = 1'b0, rst = 1'b0, if_req = 1'b0, ld_req = 1'b0, dma_req = 1'b0;
  logic        bmode = 1'b0;
  logic [31:0] if_va = 32'h0000_0000, ld_va = 32'h0000_0000;
  logic [3:0]  dly = 4'h2;
  cbb_store_t  st = '0;
  logic        if_vld, ld_vld, st_rdy, ad_oe, ale, rd_n, wr_n, ack, burst, dma_gnt;
  logic [31:0] if_dat, ld_dat, ad_in, ad_out;
  logic [1:0]  lo;
  int          fails = 0;
  int          tests_run = 0;

  always #2 clk = ~clk;

  cbb_top i_dut
  (
    .CLK_SYS_I (clk), .RST_I (rst),
    .IF_REQ_I (if_req), .IF_VADDR_I (if_va), .IF_VALID_O (if_vld), .IF_DATA_O (if_dat),
    .LD_REQ_I (ld_req), .LD_VADDR_I (ld_va), .LD_VALID_O (ld_vld), .LD_DATA_O (ld_dat),
    .ST_I (st), .ST_READY_O (st_rdy), .DMA_REQ_I (dma_req), .DMA_GRANT_O (dma_gnt),
    .AD_I (ad_in), .AD_O (ad_out), .AD_OE_O (ad_oe), .ALE_O (ale), .ADDR_LO_O (lo),
    .RD_N_O (rd_n), .WR_N_O (wr_n), .ACK_I (ack), .BURST_I (burst)
  );
  cbb_mem_model i_mem
  (
    .clk_i (clk), .rst_i (rst), .ad_i (ad_out), .ale_i (ale), .lo_i (lo), .rd_n_i (rd_n),
    .wr_n_i (wr_n), .dly_i (dly), .burst_i (bmode), .ad_o (ad_in), .ack_o (ack), .burst_o (burst)
  );

  // ------------------------------
  // Shared steps
  // ------------------------------
  task automatic stop_test();
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
      fails++;
    if (ok !== 1'b1)
      $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic give_up();
    check(1'b0, "wait ran out");
    stop_test();
  endtask

  // Bounded, so a dead handshake ends the run rather than hanging it
  task automatic wait_flag(ref logic f, input logic lvl, input int lim);
    int n;
    n = 0;
    while (f !== lvl && n++ < lim)
    begin
      @(posedge clk);
      #1;
    end
    if (f !== lvl)
      give_up();
  endtask

  task automatic rd(input bit is_ld, input logic [31:0] va, input logic [31:0] exp);
    @(posedge clk);
    ld_req <= is_ld;
    if_req <= !is_ld;
    ld_va  <= va;
    if_va  <= va;
    if (is_ld)
      wait_flag(ld_vld, 1'b1, 300);
    else
      wait_flag(if_vld, 1'b1, 300);
    check((is_ld ? ld_dat : if_dat) === exp, "read data");
    @(posedge clk);
    ld_req <= 1'b0;
    if_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_fetch();
    i_mem.rd_q = {};
    rd(1'b0, 32'h8000_1008, 32'h5A5A_1008);
    check(i_mem.rd_q.size() == 4, "line fill length");
    for (int i = 0; i < 4; i++)
      check(i_mem.rd_q[i][31:0] === 32'h0000_1000 + 32'(4 * i), "fill order");
    rd(1'b0, 32'h8000_100C, 32'h5A5A_100C);
    check(i_mem.rd_q.size() == 4, "fetch hit used bus");
    bmode <= 1'b1;
    i_mem.rd_q = {};
    rd(1'b0, 32'h8000_2004, 32'h5A5A_2004);
    check(i_mem.rd_q[3][63:32] - i_mem.rd_q[0][63:32] === 32'h0000_0003, "burst pace");
    // Uncached fetch must go to the bus every time
    rd(1'b0, 32'hA000_3008, 32'h5A5A_3008);
    rd(1'b0, 32'hA000_3008, 32'h5A5A_3008);
    check(i_mem.rd_q.size() == 12, "uncached fetch kept");
  endtask

  task automatic t_load();
    i_mem.rd_q = {};
    rd(1'b1, 32'hA000_0208, 32'h5A5A_0208);
    check(i_mem.rd_q.size() == 1 && i_mem.rd_q[0][31:0] === 32'h0000_0208, "single");
    rd(1'b1, 32'h0000_0104, 32'h1A5A_0104);
    rd(1'b1, 32'h0000_0104, 32'h1A5A_0104);
    check(i_mem.rd_q.size() == 2, "load hit used bus");
    rd(1'b1, 32'h7FFF_FFF0, 32'hE5A5_FFF0);
    rd(1'b1, 32'hFFFF_0010, 32'hA5A5_0010);
    check(i_mem.rd_q.size() == 4 && i_mem.rd_q[3][31:0] === 32'hFFFF_0010, "map");
  endtask

  task automatic t_stores();
    logic [31:0] pa;
    logic [3:0]  be;
    bit          stl;
    int          n;
    // Slow memory keeps every queued entry held
    dly <= 4'hF;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      st <= '{1'b1, 32'h8000_0400 + 32'(4 * i), (i == 2) ? 4'h3 : 4'hF, 32'hC0DE_0000 + 32'(i)};
      @(negedge clk);
      stl = (st_rdy !== 1'b1);
      for (n = 0; st_rdy !== 1'b1 && n < 100; n++)
        @(negedge clk);
      if (st_rdy !== 1'b1)
        give_up();
      check(stl == (i == 4), "store acceptance");
      @(posedge clk);
    end
    st.valid <= 1'b0;
    for (n = 0; i_mem.wr_q.size() < 5 && n < 400; n++)
      @(posedge clk);
    if (n >= 400)
      give_up();
    for (int i = 0; i < 5; i++)
    begin
      pa = 32'h0000_0400 + 32'(4 * i);
      be = (i == 2) ? 4'h3 : 4'hF;
      check(i_mem.wr_q[i][63:32] === {pa[31:4], ~be}, "address phase");
      check(i_mem.wr_q[i][31:0] === 32'hC0DE_0000 + 32'(i), "write order");
    end
    check(i_mem.peek(32'h0000_0410) === 32'hC0DE_0004, "write word");
    // Store into a cached word: merged in the cache and written through
    @(posedge clk);
    st <= '{1'b1, 32'h0000_0104, 4'h1, 32'h0000_00EE};
    @(posedge clk);
    st.valid <= 1'b0;
    rd(1'b1, 32'h0000_0104, 32'h1A5A_01EE);
    rd(1'b1, 32'h8000_0408, 32'h5A5A_0002);
    check(i_mem.peek(32'h4000_0104) === 32'h1A5A_01EE, "write through");
  endtask

  task automatic t_dma();
    @(posedge clk);
    dma_req <= 1'b1;
    wait_flag(dma_gnt, 1'b1, 20);
    repeat (4)
    begin
      @(posedge clk);
      #1;
      check(dma_gnt === 1'b1 && ad_oe === 1'b0 && ale === 1'b0, "bus kept");
    end
    @(posedge clk);
    dma_req <= 1'b0;
    wait_flag(dma_gnt, 1'b0, 5);
  endtask

  initial
  begin
    rst <= 1'b1;
    repeat (10)
      @(posedge clk);
    rst <= 1'b0;
    t_fetch();
    t_load();
    t_stores();
    t_dma();
    stop_test();
  end
endmodule
